//--- rtl/nobc_top.sv
// Option byte loader driving boot, clock, watchdog and flash guard controls
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module nobc_top (
  // Clock and power-up reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Pin reset boot request
  input wire logic pin_boot_i,
  // Option bytes from nonvolatile store
  input wire logic [7:0] boot_lock_option_byte_i,
  input wire logic [7:0] iap_boundary_option_byte_i,
  input wire logic [7:0] clock_boot_option_byte_i,
  input wire logic [7:0] watchdog_option_byte_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Flash write attempt from running program
  input wire logic flash_wr_i,
  input wire logic [15:0] flash_addr_i,
  output logic flash_wr_allow_o,
  // Program counter check
  input wire logic [15:0] pc_i,
  output logic fetch_nop_o,
  // Boot selection
  output logic boot_start_o,
  output logic boot_isp_o,
  output logic [15:0] boot_addr_o,
  // Clock source controls
  output logic osc_gain_full_o,
  output logic rc_osc_en_o,
  // Watchdog controls
  output logic wdt_en_o,
  output logic wdt_idle_run_o,
  output logic [2:0] wdt_ps_o,
  output logic [8:0] wdt_ratio_o
);
  nobc_pkg::nobc_state_t state_q;
  logic [7:0] ob0_q;
  logic [7:0] ob1_q;
  logic [7:0] ob2_q;
  logic [7:0] ob3_q;
  logic soft_boot_q;
  logic [7:0] wcr_q;
  logic app_ref_q;
  logic opt_ref_q;
  logic boot_req;
  logic boot_isp_d;
  logic [1:0] isp_code;
  logic allow;
  logic refuse;
  logic opt_wr;
  logic loading;
  logic [7:0] rd_d;
  logic loading_done_q;

  assign loading = (state_q == nobc_pkg::NOBC_LOADING);
  assign isp_code = {ob0_q[nobc_pkg::OB0_ISPAS_HI], ob0_q[nobc_pkg::OB0_ISPAS_LO]};
  assign opt_wr = reg_wr_i && (reg_addr_i >= nobc_pkg::REG_OPT0)
                  && (reg_addr_i <= nobc_pkg::REG_OPT3 || reg_addr_i == nobc_pkg::REG_OPT_WRITE);

  // Sequencer: reset, one load cycle, then run
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_q <= nobc_pkg::NOBC_IN_RESET;
    else
    begin
      case (state_q)
        nobc_pkg::NOBC_IN_RESET: state_q <= nobc_pkg::NOBC_LOADING;
        nobc_pkg::NOBC_LOADING: state_q <= nobc_pkg::NOBC_RUNNING;
        nobc_pkg::NOBC_RUNNING: state_q <= nobc_pkg::NOBC_RUNNING;
        default: state_q <= nobc_pkg::NOBC_IN_RESET;
      endcase
    end
  end

  // Held bytes change only on power-up; no write path exists
  // sample once held
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ob0_q <= nobc_pkg::OB_ERASED;
      ob1_q <= nobc_pkg::OB_ERASED;
      ob2_q <= nobc_pkg::OB_ERASED;
      ob3_q <= nobc_pkg::OB_ERASED;
    end
    else if (loading)
    begin
      ob0_q <= boot_lock_option_byte_i;
      ob1_q <= iap_boundary_option_byte_i;
      ob2_q <= clock_boot_option_byte_i;
      ob3_q <= watchdog_option_byte_i;
    end
  end

  // Soft boot select: power-up load, then software owned
  // A pin reset keeps the software choice; only power-up reloads it
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      soft_boot_q <= 1'b0;
    else if (loading)
      soft_boot_q <= ~boot_lock_option_byte_i[nobc_pkg::OB0_HWBOOT];
    else if (reg_wr_i && reg_addr_i == nobc_pkg::REG_BOOT_CTRL)
      soft_boot_q <= reg_wdata_i[nobc_pkg::BC_SOFT_BOOT];
  end

  // Watchdog control register
  // Hardware start wins over a software write in the load cycle
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      wcr_q <= nobc_pkg::WCR_RESET;
    else if (loading && !watchdog_option_byte_i[nobc_pkg::OB3_WDT_EN_N])
    begin
      wcr_q[nobc_pkg::WCR_ENABLE] <= 1'b1;
      wcr_q[nobc_pkg::WCR_IDLE] <= watchdog_option_byte_i[nobc_pkg::OB3_IDLE_RUN];
      wcr_q[nobc_pkg::WCR_PS_LSB +: 3] <= watchdog_option_byte_i[nobc_pkg::OB3_PS_LSB +: 3];
    end
    else if (!loading && reg_wr_i && reg_addr_i == nobc_pkg::REG_WDT_CTRL)
    begin
      // Enable is one-time: software can set it but never clear it
      wcr_q[nobc_pkg::WCR_ENABLE] <= wcr_q[nobc_pkg::WCR_ENABLE] | reg_wdata_i[nobc_pkg::WCR_ENABLE];
      wcr_q[nobc_pkg::WCR_IDLE] <= reg_wdata_i[nobc_pkg::WCR_IDLE];
      wcr_q[nobc_pkg::WCR_PS_LSB +: 3] <= reg_wdata_i[nobc_pkg::WCR_PS_LSB +: 3];
    end
  end

  // Refusal flags: write one clears, a new refusal wins
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      app_ref_q <= 1'b0;
      opt_ref_q <= 1'b0;
    end
    else
    begin
      if (refuse)
        app_ref_q <= 1'b1;
      else if (reg_wr_i && reg_addr_i == nobc_pkg::REG_STATUS && reg_wdata_i[nobc_pkg::ST_APP_REFUSED])
        app_ref_q <= 1'b0;
      if (opt_wr)
        opt_ref_q <= 1'b1;
      else if (reg_wr_i && reg_addr_i == nobc_pkg::REG_STATUS && reg_wdata_i[nobc_pkg::ST_OPT_REFUSED])
        opt_ref_q <= 1'b0;
    end
  end

  // Register read data, one cycle after the strobe
  always_comb
  begin
    case (reg_addr_i)
      nobc_pkg::REG_BOOT_CTRL: rd_d = {7'h00, soft_boot_q};
      nobc_pkg::REG_WDT_CTRL: rd_d = wcr_q;
      nobc_pkg::REG_OPT0: rd_d = ob0_q;
      nobc_pkg::REG_OPT1: rd_d = ob1_q;
      nobc_pkg::REG_OPT2: rd_d = ob2_q;
      nobc_pkg::REG_OPT3: rd_d = ob3_q;
      nobc_pkg::REG_STATUS:
      begin
        rd_d = 8'h00;
        rd_d[nobc_pkg::ST_APP_REFUSED] = app_ref_q;
        rd_d[nobc_pkg::ST_OPT_REFUSED] = opt_ref_q;
        rd_d[nobc_pkg::ST_LOADED] = (state_q == nobc_pkg::NOBC_RUNNING);
      end
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= 8'h00;
    // Data stands for one cycle only; idle cycles read zero
    else if (reg_rd_i)
      reg_rdata_o <= rd_d;
    else
      reg_rdata_o <= 8'h00;
  end

  // Boot decision on power-up load and on pin reset
  // A pin request before the options are held is dropped on purpose
  assign boot_req = (state_q == nobc_pkg::NOBC_RUNNING) && (loading_done_q || pin_boot_i);
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      loading_done_q <= 1'b0;
    else
      loading_done_q <= loading;
  end

  always_comb
  begin
    boot_isp_d = !ob2_q[nobc_pkg::OB2_PIN_FORCE] || soft_boot_q;
    if (isp_code == nobc_pkg::ISP_CODE_NONE)
      boot_isp_d = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      boot_start_o <= 1'b0;
      boot_isp_o <= 1'b0;
      boot_addr_o <= nobc_pkg::AP_START;
    end
    else
    begin
      boot_start_o <= boot_req;
      if (boot_req)
      begin
        boot_isp_o <= boot_isp_d;
        boot_addr_o <= boot_isp_d ? nobc_pkg::isp_start(isp_code) : nobc_pkg::AP_START;
      end
    end
  end

  // Flash access guard
  // Verdicts are registered so the outputs never glitch
  nobc_guard u_guard (
    .bound_i(ob1_q[7:nobc_pkg::OB1_BOUND_LSB]),
    .isp_code_i(isp_code),
    .wr_req_i(flash_wr_i),
    .wr_addr_i(flash_addr_i),
    .allow_o(allow),
    .refuse_o(refuse)
  );

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      flash_wr_allow_o <= 1'b0;
      fetch_nop_o <= 1'b0;
    end
    else
    begin
      flash_wr_allow_o <= allow;
      fetch_nop_o <= (pc_i > nobc_pkg::FLASH_LAST);
    end
  end

  // Clock source and watchdog outputs
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      osc_gain_full_o <= 1'b1;
      rc_osc_en_o <= 1'b0;
      wdt_en_o <= 1'b0;
      wdt_idle_run_o <= 1'b0;
      wdt_ps_o <= 3'h0;
      wdt_ratio_o <= 9'h002;
    end
    else
    begin
      osc_gain_full_o <= ob2_q[nobc_pkg::OB2_OSC_GAIN];
      rc_osc_en_o <= ~ob2_q[nobc_pkg::OB2_RC_EN_N];
      wdt_en_o <= wcr_q[nobc_pkg::WCR_ENABLE];
      wdt_idle_run_o <= wcr_q[nobc_pkg::WCR_IDLE];
      wdt_ps_o <= wcr_q[nobc_pkg::WCR_PS_LSB +: 3];
      wdt_ratio_o <= nobc_pkg::wdt_ratio(wcr_q[nobc_pkg::WCR_PS_LSB +: 3]);
    end
  end
endmodule
`default_nettype wire

//--- rtl/nobc_pkg.sv
// Shared constants and helpers for the option byte boot configuration block
package nobc_pkg;
  // Flash geometry
  localparam int ADDR_W = 16;
  localparam logic [15:0] FLASH_SIZE = 16'h3e00;
  localparam logic [15:0] FLASH_LAST = 16'h3dff;
  localparam logic [15:0] IAP_UNIT = 16'h0200;
  localparam logic [6:0] IAP_NONE = 7'h7f;
  // ISP start encodings
  localparam logic [1:0] ISP_CODE_NONE = 2'h3;
  localparam logic [15:0] ISP_START_0 = 16'h3000;
  localparam logic [15:0] ISP_START_1 = 16'h3400;
  localparam logic [15:0] ISP_START_2 = 16'h3800;
  localparam logic [15:0] AP_START = 16'h0000;
  // Option byte field positions
  localparam int OB0_ISPAS_HI = 5;
  localparam int OB0_ISPAS_LO = 4;
  localparam int OB0_HWBOOT = 3;
  localparam int OB1_BOUND_LSB = 1;
  localparam int OB2_OSC_GAIN = 6;
  localparam int OB2_PIN_FORCE = 5;
  localparam int OB2_RC_EN_N = 1;
  localparam int OB3_WDT_EN_N = 5;
  localparam int OB3_IDLE_RUN = 3;
  localparam int OB3_PS_LSB = 0;
  // Erased option byte value
  localparam logic [7:0] OB_ERASED = 8'hff;
  // Watchdog control register fields
  localparam int WCR_RESET_FLAG = 7;
  localparam int WCR_ENABLE = 5;
  localparam int WCR_CLEAR = 4;
  localparam int WCR_IDLE = 3;
  localparam int WCR_PS_LSB = 0;
  localparam logic [7:0] WCR_RESET = 8'h00;
  // Register map
  localparam int REG_AW = 4;
  localparam logic [3:0] REG_BOOT_CTRL = 4'h0;
  localparam logic [3:0] REG_WDT_CTRL = 4'h1;
  localparam logic [3:0] REG_OPT0 = 4'h2;
  localparam logic [3:0] REG_OPT1 = 4'h3;
  localparam logic [3:0] REG_OPT2 = 4'h4;
  localparam logic [3:0] REG_OPT3 = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_OPT_WRITE = 4'h7;
  // Status bits and boot control bit
  localparam int ST_APP_REFUSED = 0;
  localparam int ST_OPT_REFUSED = 1;
  localparam int ST_LOADED = 2;
  localparam int BC_SOFT_BOOT = 0;

  typedef enum logic [1:0] {
    NOBC_IN_RESET = 2'b00,
    NOBC_LOADING = 2'b01,
    NOBC_RUNNING = 2'b11
  } nobc_state_t;

  // Start address of ISP code for a two-bit code
  function automatic logic [15:0] isp_start(input logic [1:0] code);
    case (code)
      2'h0: isp_start = ISP_START_0;
      2'h1: isp_start = ISP_START_1;
      2'h2: isp_start = ISP_START_2;
      default: isp_start = FLASH_SIZE;
    endcase
  endfunction

  // Watchdog divide ratio for a three-bit prescaler code
  function automatic logic [8:0] wdt_ratio(input logic [2:0] code);
    wdt_ratio = 9'h002 << code;
  endfunction
endpackage

//--- rtl/nobc_guard.sv
// Flash write guard: allows writes only inside the in-application data region
`timescale 1ns/100ps
`default_nettype none
module nobc_guard (
  // Held options
  input wire logic [6:0] bound_i,
  input wire logic [1:0] isp_code_i,
  // Write attempt
  input wire logic wr_req_i,
  input wire logic [15:0] wr_addr_i,
  // Verdict
  output logic allow_o,
  output logic refuse_o
);
  logic [15:0] lo;
  logic [15:0] hi;
  logic empty;

  always_comb
  begin
    lo = {bound_i, 9'h000};
    hi = nobc_pkg::isp_start(isp_code_i);
    empty = (bound_i == nobc_pkg::IAP_NONE) || (lo >= hi);
    allow_o = wr_req_i && !empty && (wr_addr_i >= lo) && (wr_addr_i < hi);
    refuse_o = wr_req_i && !allow_o;
  end
endmodule
`default_nettype wire

//--- verif/nobc_monitor.sv
// Assertion checker for the option byte loader
`timescale 1ns/100ps
`default_nettype none
module nobc_monitor (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Stimulus
  input wire logic pin_boot_i,
  input wire logic [7:0] boot_lock_option_byte_i,
  input wire logic [7:0] iap_boundary_option_byte_i,
  input wire logic [7:0] clock_boot_option_byte_i,
  input wire logic [7:0] watchdog_option_byte_i,
  input wire logic flash_wr_i,
  input wire logic [15:0] flash_addr_i,
  input wire logic [15:0] pc_i,
  // Responses
  input wire logic flash_wr_allow_o,
  input wire logic fetch_nop_o,
  input wire logic boot_start_o,
  input wire logic boot_isp_o,
  input wire logic [15:0] boot_addr_o,
  input wire logic osc_gain_full_o,
  input wire logic rc_osc_en_o,
  input wire logic wdt_en_o,
  input wire logic wdt_idle_run_o,
  input wire logic [2:0] wdt_ps_o,
  input wire logic [8:0] wdt_ratio_o
);
  logic [1:0] cnt_q;
  logic [7:0] b0_q, b1_q, b2_q, b3_q;
  logic [15:0] hi, lo;
  logic isp;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // Edges since reset release; options are held at the second
  always_ff @(posedge mclk_i or negedge nrst_i)
    if (!nrst_i)
      cnt_q <= 2'h0;
    else if (cnt_q != 2'h3)
      cnt_q <= cnt_q + 2'h1;
  always_ff @(posedge mclk_i)
    if (cnt_q == 2'h1)
    begin
      b0_q <= boot_lock_option_byte_i;
      b1_q <= iap_boundary_option_byte_i;
      b2_q <= clock_boot_option_byte_i;
      b3_q <= watchdog_option_byte_i;
    end
  assign hi = (b0_q[5:4] == 2'h3) ? 16'h3e00 : 16'h3000 + {4'h0, b0_q[5:4], 10'h000};
  assign lo = {b1_q[7:1], 9'h000};
  assign isp = (!b2_q[5] || !b0_q[3]) && b0_q[5:4] != 2'h3;
  AST_NOP: assert property (nrst_i |=> fetch_nop_o == ($past(pc_i) > 16'h3dff))
    else $error("fetch nop wrong");
  AST_ALLOW_CAUSE: assert property (flash_wr_allow_o |-> $past(flash_wr_i))
    else $error("allow without attempt");
  AST_GUARD: assert property (flash_wr_i && cnt_q == 2'h3 |=>
    flash_wr_allow_o == ($past(flash_addr_i) >= lo && $past(flash_addr_i) < hi))
    else $error("guard verdict wrong");
  AST_WDT: assert property (cnt_q == 2'h2 |=> wdt_en_o == !b3_q[5] &&
    wdt_idle_run_o == (!b3_q[5] && b3_q[3]) && wdt_ps_o == (b3_q[5] ? 3'h0 : b3_q[2:0]))
    else $error("watchdog preset wrong");
  AST_RATIO: assert property (wdt_ratio_o == (9'h002 << wdt_ps_o))
    else $error("ratio wrong");
  AST_CLK: assert property (cnt_q == 2'h2 |=>
    osc_gain_full_o == b2_q[6] && rc_osc_en_o == !b2_q[1])
    else $error("clock controls wrong");
  AST_HOLD: assert property (cnt_q == 2'h3 && $past(cnt_q) == 2'h3 |->
    $stable({osc_gain_full_o, rc_osc_en_o}))
    else $error("held option moved");
  AST_BOOT: assert property (cnt_q == 2'h2 |=> boot_start_o &&
    boot_isp_o == isp && boot_addr_o == (isp ? hi : 16'h0000))
    else $error("power-up boot wrong");
  AST_PIN: assert property (pin_boot_i && cnt_q == 2'h3 |=>
    boot_start_o && boot_isp_o == isp)
    else $error("pin boot wrong");
endmodule
bind nobc_top nobc_monitor u_mon (.mclk_i, .nrst_i, .pin_boot_i, .boot_lock_option_byte_i,
  .iap_boundary_option_byte_i, .clock_boot_option_byte_i, .watchdog_option_byte_i,
  .flash_wr_i, .flash_addr_i, .pc_i, .flash_wr_allow_o, .fetch_nop_o, .boot_start_o,
  .boot_isp_o, .boot_addr_o, .osc_gain_full_o, .rc_osc_en_o, .wdt_en_o, .wdt_idle_run_o,
  .wdt_ps_o, .wdt_ratio_o);
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the option byte loader
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk_i = 1'b0, nrst_i = 1'b0, pin_boot_i = 1'b0;
  logic [7:0] boot_lock_option_byte_i = 8'hff, iap_boundary_option_byte_i = 8'hff;
  logic [7:0] clock_boot_option_byte_i = 8'hff, watchdog_option_byte_i = 8'hff;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, d;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, flash_wr_i = 1'b0, flash_wr_allow_o, fetch_nop_o;
  logic [15:0] flash_addr_i = 16'h0000, pc_i = 16'h0000, boot_addr_o;
  logic boot_start_o, boot_isp_o, osc_gain_full_o, rc_osc_en_o, wdt_en_o, wdt_idle_run_o;
  logic [2:0] wdt_ps_o;
  logic [8:0] wdt_ratio_o;
  int mismatches = 0, compares = 0;
  nobc_top dut (.mclk_i, .nrst_i, .pin_boot_i, .boot_lock_option_byte_i,
    .iap_boundary_option_byte_i, .clock_boot_option_byte_i, .watchdog_option_byte_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .flash_wr_i,
    .flash_addr_i, .flash_wr_allow_o, .pc_i, .fetch_nop_o, .boot_start_o, .boot_isp_o,
    .boot_addr_o, .osc_gain_full_o, .rc_osc_en_o, .wdt_en_o, .wdt_idle_run_o, .wdt_ps_o,
    .wdt_ratio_o);
  always #5 mclk_i = ~mclk_i;
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
    @(posedge mclk_i);
  endtask
  task automatic fl(input logic [15:0] a, input logic e);
    flash_addr_i <= a;
    flash_wr_i <= 1'b1;
    @(posedge mclk_i);
    flash_wr_i <= 1'b0;
    #1;
    chk("allow", e, flash_wr_allow_o);
    @(posedge mclk_i);
  endtask
  task automatic pcs(input logic [15:0] p, input logic e);
    pc_i <= p;
    @(posedge mclk_i);
    #1;
    chk("nop", e, fetch_nop_o);
    @(posedge mclk_i);
  endtask
  // Power-up with given option bytes; ex packs isp,gain,rc,en,idle,ps
  task automatic boot_chk(input logic [31:0] ob, input logic [15:0] ea, input logic [7:0] ex);
    nrst_i <= 1'b0;
    {boot_lock_option_byte_i, iap_boundary_option_byte_i, clock_boot_option_byte_i,
      watchdog_option_byte_i} <= ob;
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    chk("start", 1'b1, boot_start_o);
    chk("isp", ex[7], boot_isp_o);
    chk("addr", ea, boot_addr_o);
    chk("gain", ex[6], osc_gain_full_o);
    chk("rc", ex[5], rc_osc_en_o);
    chk("wdt_en", ex[4], wdt_en_o);
    chk("idle", ex[3], wdt_idle_run_o);
    chk("ps", ex[2:0], wdt_ps_o);
    chk("ratio", 16'h0002 << ex[2:0], wdt_ratio_o);
    @(posedge mclk_i);
  endtask
  // Options change after power-up, then a pin boot and refused writes
  task automatic t_hold();
    {boot_lock_option_byte_i, iap_boundary_option_byte_i, clock_boot_option_byte_i,
      watchdog_option_byte_i} <= 32'h0400d5c0;
    repeat (4) @(posedge mclk_i);
    pin_boot_i <= 1'b1;
    @(posedge mclk_i);
    pin_boot_i <= 1'b0;
    #1;
    chk("pin_start", 1'b1, boot_start_o);
    chk("pin_isp", 1'b1, boot_isp_o);
    chk("pin_addr", 16'h3400, boot_addr_o);
    chk("held_gain", 1'b0, osc_gain_full_o);
    @(posedge mclk_i);
    wr(4'h7, 8'h00);
    wr(4'h2, 8'h00);
    rd(4'h2);
    chk("opt0", 8'hd7, d);
    rd(4'h6);
    chk("refused", 8'h07, d);
    rd(4'h8);
    chk("unmapped", 8'h00, d);
  endtask
  // Loaded boot select, status clears and a software watchdog update
  task automatic t_regs();
    rd(4'h0);
    chk("soft_boot", 8'h01, d);
    wr(4'h6, 8'h03);
    rd(4'h6);
    chk("cleared", 8'h04, d);
    wr(4'h1, 8'h02);
    rd(4'h1);
    chk("wcr", 8'h22, d);
    #1;
    chk("ps_sw", 3'h2, wdt_ps_o);
    chk("ratio_sw", 16'h0008, wdt_ratio_o);
    @(posedge mclk_i);
  endtask
  initial
  begin
    boot_chk(32'hd731bddd, 16'h3400, 8'hbd);
    fl(16'h2fff, 1'b0);
    fl(16'h3000, 1'b1);
    fl(16'h33ff, 1'b1);
    fl(16'h3400, 1'b0);
    fl(16'h0000, 1'b0);
    pcs(16'h3dff, 1'b0);
    pcs(16'h3e00, 1'b1);
    pcs(16'hffff, 1'b1);
    pc_i <= 16'h0000;
    t_hold();
    t_regs();
    boot_chk(32'hffffffff, 16'h0000, 8'h40);
    fl(16'h1000, 1'b0);
    boot_chk(32'hcfffdfd0, 16'h3000, 8'hd0);
    boot_chk(32'hffffdfd7, 16'h0000, 8'h57);
    boot_chk(32'he7ffffff, 16'h3800, 8'hc0);
    print_verdict();
  end
  initial
  begin
    #20000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
